// File: rtl/mmap_ctrl_pkg.sv
// Purpose: constants and carriers for the memory map control block
// Assumes: byte-wide registers on a plain address port
// Notes:   mode and direct page offsets are local choices
package mmap_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MODE  = 8'h0b;
	localparam logic [7:0] OFS_ZPAGE = 8'h11;
	localparam logic [7:0] OFS_PROGRAM_PAGE_INDEX = 8'h30;
	localparam int MODE_BIT = 7;
	localparam logic [7:0] PROGRAM_PAGE_INDEX_RESET = 8'h0e;
	localparam logic [7:0] ZPAGE_RESET = 8'h00;
	localparam logic [3:0] PAGE_LOW  = 4'h0c;
	localparam logic [3:0] PAGE_MID  = 4'h0d;
	localparam logic [3:0] PAGE_TOP  = 4'h0f;
	localparam logic [7:0] PIX_MASK  = 8'h0f;

	typedef enum logic [0:0] {
		SPECIAL_SINGLE_CHIP = 1'b0,
		NORMAL_SINGLE_CHIP  = 1'b1
	} op_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic       wr;
		logic [3:0] page;
	} call_req_t;
endpackage : mmap_ctrl_pkg

// File: rtl/memory_map_mode_paging.sv
// Purpose: mode, direct page and program page registers with mapping
// Assumes: inputs synchronous to clock; mode pin held during reset
// Notes:   mode 1 = normal single chip, 0 = special single chip
// Contract
// (R1) mode pin sets operating mode in reset; captured into bit 7 after
// (R2) disallowed mode write leaves bit; outside special mode locks it
// (R3) mode writes ignored while secured
// (R4) all three registers readable anytime, no read side effects
// (R5) direct page writes free in special mode, write-once in normal
// (R6) direct access takes address bits 15:8 from direct page
// (R7) four page bits select flash block in 0x8000-0xbfff window
// (R8) program page resets to 0x0e
// (R9) fixed pages 0x0c, 0x0d, 0x0f for unpaged regions
// (R10) core reads and writes program page over dedicated call path
// (R11) call path page update done before instruction ends
// (R12) normal mode runs applications with no external bus
// (R13) special mode puts background debug in control
// (R14) mode pin sampled at reset release
// (R15) upper program page bits read zero, writes ignored
// (R16) write locks cleared only by reset
module memory_map_mode_paging
	import mmap_ctrl_pkg::*;
(
	input  wire logic              clock,          // system clock
	input  wire logic              rst_n,          // sync reset, low
	input  wire logic              mode_pin,       // external mode pin
	input  wire logic              secured,        // device secured
	input  wire reg_req_t          req,            // register request
	output logic [7:0]             rdata,          // read data
	input  wire call_req_t         call_req,       // call/return write
	output logic [3:0]             call_page,      // page for call path
	input  wire logic              direct_access,  // direct addr access
	input  wire logic [7:0]        direct_offset,  // low address byte
	input  wire logic [15:0]       local_addr,     // local cpu address
	output logic [15:0]            direct_addr,    // direct local address
	output logic [17:0]            global_addr,    // global address
	output logic                   normal_mode,    // normal single chip
	output logic                   background_debug, // debug in control
	output logic                   ext_bus_en      // external bus enable
);
	logic       mode_select_bit;
	logic       mode_lock;
	logic       in_reset;
	logic [7:0] zero_page_base;
	logic       zpage_written;
	logic [3:0] page_index_bits;

	wire sel_mode  = req.addr == OFS_MODE;
	wire sel_zpage = req.addr == OFS_ZPAGE;
	wire sel_program_page_index = req.addr == OFS_PROGRAM_PAGE_INDEX;
	wire wr_mode   = req.wr && sel_mode;
	wire wr_zpage  = req.wr && sel_zpage;
	wire wr_program_page_index  = req.wr && sel_program_page_index;
	// only normal to special is barred when unsecured; special may go either way
	wire mode_req     = req.wdata[MODE_BIT];
	wire mode_changes = mode_req != mode_select_bit;
	wire mode_allowed = (mode_select_bit == SPECIAL_SINGLE_CHIP);
	wire mode_ok      = wr_mode && !secured && !mode_lock; // R3
	wire zpage_ok     = wr_zpage && // R5
		(mode_select_bit == SPECIAL_SINGLE_CHIP || !zpage_written);
	wire [7:0] mode_rd  = {mode_select_bit, 7'h00};
	wire [7:0] program_page_index_rd = {4'h0, page_index_bits}; // R15
	wire [7:0] next_rdata = sel_mode  ? mode_rd : // R4
		sel_zpage ? zero_page_base :
		sel_program_page_index ? program_page_index_rd : 8'h00;
	// call path wins over a bus write in the same cycle
	wire [3:0] next_page = call_req.wr ? call_req.page : // R10
		wr_program_page_index ? (req.wdata[3:0] & PIX_MASK[3:0]) : page_index_bits;
	wire [1:0] region = local_addr[15:14];
	wire [3:0] map_page = (region == 2'b00) ? PAGE_LOW : // R9
		(region == 2'b01) ? PAGE_MID :
		(region == 2'b10) ? next_page : PAGE_TOP; // R7 R11
	wire [15:0] next_direct = {zero_page_base, direct_offset}; // R6

	// mode held normal through reset, loads the pin on the first clock after release
	always_ff @(posedge clock) begin
		in_reset <= !rst_n;
		if (!rst_n) begin
			mode_select_bit <= NORMAL_SINGLE_CHIP;
			mode_lock <= 1'b0; // R16
		end else if (in_reset) begin
			mode_select_bit <= mode_pin; // R1 R14
		end else if (mode_ok) begin
			if (mode_changes && mode_allowed)
				mode_select_bit <= mode_req;
			else if (mode_changes && mode_select_bit) // R2
				mode_lock <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			zero_page_base <= ZPAGE_RESET;
			zpage_written <= 1'b0; // R16
			page_index_bits <= PROGRAM_PAGE_INDEX_RESET[3:0]; // R8
		end else begin
			if (zpage_ok)
				zero_page_base <= req.wdata;
			if (wr_zpage)
				zpage_written <= 1'b1;
			page_index_bits <= next_page;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			call_page <= PROGRAM_PAGE_INDEX_RESET[3:0];
			direct_addr <= 16'h0000;
			global_addr <= 18'h00000;
			normal_mode <= 1'b0;
			background_debug <= 1'b0;
			ext_bus_en <= 1'b0;
		end else begin
			rdata <= req.rd ? next_rdata : 8'h00;
			call_page <= next_page;
			direct_addr <= direct_access ? next_direct : local_addr;
			global_addr <= {map_page, local_addr[13:0]};
			normal_mode <= mode_select_bit; // R12
			background_debug <= !mode_select_bit; // R13
			ext_bus_en <= 1'b0; // R12
		end
	end

	logic seen_rst;
	always_ff @(posedge clock) begin
		seen_rst <= rst_n ? seen_rst : 1'b1;
	end

	// reset and mode capture
	AST_PROGRAM_PAGE_INDEX_RESET: assert property (@(posedge clock) // R8
		$rose(rst_n) |-> page_index_bits == PROGRAM_PAGE_INDEX_RESET[3:0])
		else $error("page index not reset value");

	AST_MODE_CAPTURE: assert property (@(posedge clock) // R1
		seen_rst && $past(rst_n) && $past(in_reset)
		|-> mode_select_bit == $past(mode_pin))
		else $error("mode pin not captured");

	AST_RESET_MODE: assert property (@(posedge clock) // R14
		!rst_n
		|=> in_reset)
		else $error("reset release not tracked");

	AST_RESET_REGS: assert property (@(posedge clock) // R16
		!rst_n
		|=> !mode_lock && !zpage_written && page_index_bits == 4'he)
		else $error("locks or page not cleared by reset");

	// mode control
	AST_SECURED_MODE: assert property (@(posedge clock) // R3
		disable iff (!rst_n) !in_reset && secured && wr_mode
		|=> $stable(mode_select_bit))
		else $error("mode changed while secured");

	AST_LOCK_HOLDS: assert property (@(posedge clock) // R2
		disable iff (!rst_n) mode_lock && !in_reset
		|=> $stable(mode_select_bit) && mode_lock)
		else $error("locked mode bit changed");

	AST_SPECIAL_ALLOWED: assert property (@(posedge clock) // R2
		disable iff (!rst_n) mode_ok && !in_reset && !mode_select_bit
		|=> mode_select_bit == $past(mode_req))
		else $error("allowed mode write not taken");

	AST_NORMAL_REFUSED: assert property (@(posedge clock) // R2
		disable iff (!rst_n) mode_ok && !in_reset && mode_select_bit
		&& !mode_req |=> mode_select_bit && mode_lock)
		else $error("refused mode write not locked");

	AST_NO_LOCK_SPECIAL: assert property (@(posedge clock) // R2
		disable iff (!rst_n) !in_reset && !mode_select_bit && !mode_lock
		|=> !mode_lock)
		else $error("lock set in special mode");

	AST_SECURED_NO_LOCK: assert property (@(posedge clock) // R3
		disable iff (!rst_n) !in_reset && secured && !mode_lock
		|=> !mode_lock)
		else $error("lock set while secured");

	AST_MODE_HOLD_IDLE: assert property (@(posedge clock) // R1
		disable iff (!rst_n) !in_reset && !mode_ok
		|=> $stable(mode_select_bit))
		else $error("mode bit changed without write");

	AST_LOCK_STICKY: assert property (@(posedge clock) // R16
		disable iff (!rst_n) mode_lock
		|=> mode_lock)
		else $error("mode lock cleared without reset");

	AST_NORMAL_OUT: assert property (@(posedge clock) // R12
		disable iff (!rst_n) 1'b1
		|=> normal_mode == $past(mode_select_bit))
		else $error("normal mode output wrong");

	AST_DEBUG_OUT: assert property (@(posedge clock) // R13
		disable iff (!rst_n) 1'b1
		|=> background_debug == !$past(mode_select_bit))
		else $error("debug control output wrong");

	AST_MODES_EXCLUSIVE: assert property (@(posedge clock) // R13
		disable iff (!rst_n) $past(rst_n)
		|-> normal_mode != background_debug)
		else $error("mode outputs not exclusive");

	AST_NO_EXT_BUS: assert property (@(posedge clock) // R12
		disable iff (!rst_n)
		ext_bus_en == 1'b0)
		else $error("external bus enabled");

	// register reads
	AST_READ_PROGRAM_PAGE_INDEX: assert property (@(posedge clock) // R15
		disable iff (!rst_n) req.rd && sel_program_page_index
		|=> rdata[7:4] == 4'h0 && rdata[3:0] == $past(page_index_bits))
		else $error("page read wrong");

	AST_READ_MODE: assert property (@(posedge clock) // R4
		disable iff (!rst_n) req.rd && sel_mode
		|=> rdata == {$past(mode_select_bit), 7'h00})
		else $error("mode read wrong");

	AST_READ_ZPAGE: assert property (@(posedge clock) // R4
		disable iff (!rst_n) req.rd && sel_zpage
		|=> rdata == $past(zero_page_base))
		else $error("direct page read wrong");

	AST_RDATA_IDLE: assert property (@(posedge clock) // R4
		disable iff (!rst_n) !req.rd
		|=> rdata == 8'h00)
		else $error("read data outside read cycle");

	AST_READ_NO_EFFECT: assert property (@(posedge clock) // R4
		disable iff (!rst_n) req.rd && !req.wr && !call_req.wr && !in_reset
		|=> $stable(page_index_bits) && $stable(zero_page_base))
		else $error("read changed a register");

	// direct page
	AST_ZPAGE_ONCE: assert property (@(posedge clock) // R5
		disable iff (!rst_n) zpage_written && mode_select_bit
		&& !in_reset |=> $stable(zero_page_base))
		else $error("direct page rewritten in normal mode");

	AST_ZPAGE_FREE: assert property (@(posedge clock) // R5
		disable iff (!rst_n) wr_zpage && !mode_select_bit
		|=> zero_page_base == $past(req.wdata))
		else $error("special mode direct write lost");

	AST_ZPAGE_FIRST: assert property (@(posedge clock) // R5
		disable iff (!rst_n) wr_zpage && !zpage_written
		|=> zero_page_base == $past(req.wdata))
		else $error("first direct write lost");

	AST_ZPAGE_HOLD: assert property (@(posedge clock) // R5
		disable iff (!rst_n) !wr_zpage
		|=> $stable(zero_page_base))
		else $error("direct page changed without write");

	AST_ZPAGE_MARK: assert property (@(posedge clock) // R5
		disable iff (!rst_n) wr_zpage
		|=> zpage_written)
		else $error("direct write not recorded");

	AST_WRITTEN_STICKY: assert property (@(posedge clock) // R16
		disable iff (!rst_n) zpage_written
		|=> zpage_written)
		else $error("write-once flag cleared without reset");

	AST_DIRECT_MAP: assert property (@(posedge clock) // R6
		disable iff (!rst_n) direct_access
		|=> direct_addr[15:8] == $past(zero_page_base))
		else $error("direct page not applied");

	AST_DIRECT_LOW: assert property (@(posedge clock) // R6
		disable iff (!rst_n) direct_access
		|=> direct_addr[7:0] == $past(direct_offset))
		else $error("direct offset not applied");

	AST_LOCAL_PASS: assert property (@(posedge clock) // R6
		disable iff (!rst_n) !direct_access
		|=> direct_addr == $past(local_addr))
		else $error("local address not passed");

	// program page and mapping
	AST_CALL_PAGE: assert property (@(posedge clock) // R11
		disable iff (!rst_n) call_req.wr
		|=> page_index_bits == $past(call_req.page))
		else $error("call page not applied");

	AST_CALL_WINS: assert property (@(posedge clock) // R10
		disable iff (!rst_n) call_req.wr && wr_program_page_index
		|=> page_index_bits == $past(call_req.page))
		else $error("bus write beat call path");

	AST_CALL_NEXT_OUT: assert property (@(posedge clock) // R11
		disable iff (!rst_n) call_req.wr
		|=> call_page == $past(call_req.page))
		else $error("call page output late");

	AST_CALL_PAGE_OUT: assert property (@(posedge clock) // R10
		disable iff (!rst_n)
		call_page == page_index_bits)
		else $error("call page output differs");

	AST_PROGRAM_PAGE_INDEX_WRITE: assert property (@(posedge clock) // R7
		disable iff (!rst_n) wr_program_page_index && !call_req.wr
		|=> page_index_bits == $past(req.wdata[3:0]))
		else $error("page write not taken");

	AST_PAGE_HOLDS: assert property (@(posedge clock) // R7
		disable iff (!rst_n) !wr_program_page_index && !call_req.wr
		|=> $stable(page_index_bits))
		else $error("page changed without write");

	AST_FIXED_PAGE: assert property (@(posedge clock) // R9
		disable iff (!rst_n) local_addr[15:14] == 2'b11
		|=> global_addr[17:14] == PAGE_TOP)
		else $error("top region not fixed page");

	AST_LOW_PAGE: assert property (@(posedge clock) // R9
		disable iff (!rst_n) local_addr[15:14] == 2'b00
		|=> global_addr[17:14] == PAGE_LOW)
		else $error("low region not fixed page");

	AST_MID_PAGE: assert property (@(posedge clock) // R9
		disable iff (!rst_n) local_addr[15:14] == 2'b01
		|=> global_addr[17:14] == PAGE_MID)
		else $error("middle region not fixed page");

	AST_WINDOW_PAGE: assert property (@(posedge clock) // R7
		disable iff (!rst_n) local_addr[15:14] == 2'b10
		|=> global_addr[17:14] == page_index_bits)
		else $error("window not mapped by page index");

	AST_OFFSET_PASS: assert property (@(posedge clock) // R7
		disable iff (!rst_n) 1'b1
		|=> global_addr[13:0] == $past(local_addr[13:0]))
		else $error("page offset not passed");

	COV_CALL: cover property (@(posedge clock) call_req.wr);
	COV_LOCK: cover property (@(posedge clock) $rose(mode_lock));
	COV_ZPAGE: cover property (@(posedge clock) zpage_ok);
	COV_MODE_UP: cover property (@(posedge clock) mode_ok && !mode_select_bit);
	COV_WINDOW: cover property (@(posedge clock) call_req.wr && region == 2'b10);
endmodule : memory_map_mode_paging

// File: tb/cpu_call_model.sv
// Purpose: cpu core side of the call/return page path
// Assumes: go is a one-cycle pulse from the bench
// Notes:   call request follows go by one clock
module cpu_call_model
	import mmap_ctrl_pkg::*;
(
	input  wire logic       clock,    // system clock
	input  wire logic       go,       // start a call
	input  wire logic [3:0] pg,       // page to load
	output call_req_t       call_req  // call path request
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(posedge clock) call_req <= '{wr: go, page: pg};
endmodule : cpu_call_model

// File: tb/test_memory_map_mode_paging.sv
// Purpose: register, mode and paging checks of the memory map block
// Assumes: one clock, synchronous active-low reset
// Notes:   normal mode pass first, then special mode pass
module test_memory_map_mode_paging;
	import mmap_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rst_n, mode_pin, secured, direct_access, go;
	logic        normal_mode, background_debug, ext_bus_en;
	logic [3:0]  pg, call_page;
	logic [7:0]  direct_offset, rdata;
	logic [15:0] local_addr, direct_addr;
	logic [17:0] global_addr;
	reg_req_t    req;
	call_req_t   call_req;
	int          num_errors = 0;
	int          num_checks = 0;
	memory_map_mode_paging uut (.clock, .rst_n, .mode_pin, .secured, .req,
		.rdata, .call_req, .call_page, .direct_access, .direct_offset,
		.local_addr, .direct_addr, .global_addr, .normal_mode,
		.background_debug, .ext_bus_en);
	cpu_call_model cpu (.clock, .go, .pg, .call_req);
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(logic [17:0] got, logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		req <= '0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clock);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req <= '0;
		#1;
		chk(18'(rdata), 18'(exp));
	endtask : rd
	task automatic ga(logic [15:0] a, logic [17:0] exp);
		@(posedge clock);
		local_addr <= a;
		repeat (2) @(posedge clock);
		#1;
		chk(global_addr, exp);
	endtask : ga
	task automatic boot(logic pin);
		rst_n <= 1'b0;
		mode_pin <= pin;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
	endtask : boot
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		#5000;
		num_errors++;
		test_done;
	end
	initial begin
		{req, secured, direct_access, direct_offset, local_addr, go, pg} <= '0;
		boot(1'b1);
		chk(18'(normal_mode), 18'h1);
		chk(18'(ext_bus_en), 18'h0);
		rd(OFS_PROGRAM_PAGE_INDEX, PROGRAM_PAGE_INDEX_RESET);
		rd(OFS_MODE, 8'h80);
		wr(OFS_ZPAGE, 8'h80);
		wr(OFS_ZPAGE, 8'h40);
		rd(OFS_ZPAGE, 8'h80);
		wr(OFS_MODE, 8'h00);
		rd(OFS_MODE, 8'h80);
		wr(OFS_PROGRAM_PAGE_INDEX, 8'hf5);
		rd(OFS_PROGRAM_PAGE_INDEX, 8'h05);
		ga(16'h9abc, {4'h5, 14'h1abc});
		ga(16'h0123, {PAGE_LOW, 14'h0123});
		ga(16'h4567, {PAGE_MID, 14'h0567});
		ga(16'hc001, {PAGE_TOP, 14'h0001});
		@(posedge clock);
		go <= 1'b1;
		pg <= 4'h3;
		direct_access <= 1'b1;
		direct_offset <= 8'h12;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		#1;
		chk(18'(call_page), 18'h3);
		chk(18'(direct_addr), 18'h08012);
		rd(OFS_PROGRAM_PAGE_INDEX, 8'h03);
		boot(1'b0);
		chk(18'(background_debug), 18'h1);
		rd(OFS_ZPAGE, ZPAGE_RESET);
		wr(OFS_ZPAGE, 8'h11);
		wr(OFS_ZPAGE, 8'h22);
		rd(OFS_ZPAGE, 8'h22);
		secured <= 1'b1;
		wr(OFS_MODE, 8'h80);
		rd(OFS_MODE, 8'h00);
		secured <= 1'b0;
		wr(OFS_MODE, 8'h80);
		rd(OFS_MODE, 8'h80);
		test_done;
	end
endmodule : test_memory_map_mode_paging
